// [crc_clock_ratio_control.sv]
`timescale 1ns/1ps
`include "crc_params.svh"

module crc_clock_ratio_control (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic standby_i,
   input wire logic osc_stop_i,
   input wire logic ref_clk_level_i,
   output crc_pkg::crc_ratios_t ratios_o,
   output logic clk_pin_o,
   output logic clk_pin_oe_o,
   output logic tim_clk_en_o,
   output logic cnv_clk_en_o,
   output logic reinit_o,
   output logic hc_pins_hiz_o
);
   import crc_pkg::*;

   crc_state_t st_r;
   crc_state_t st_nxt;
   logic clk_pin_r;
   logic clk_pin_oe_r;
   logic hiz_r;
   logic tim_en_r;
   logic cnv_en_r;
   crc_ratios_t ratios_r;

   function automatic logic [7:0] aux_image(input logic [1:0] sel);
      aux_image = {`CRC_AUX_FIXED, sel};
   endfunction : aux_image

   function automatic logic [2:0] field3(input logic [15:0] v, input int lsb);
      field3 = v[lsb +: `CRC_DIV_FIELD_W];
   endfunction : field3

   logic wr_acc;
   logic rd_acc;
   logic hit_div;
   logic hit_tim;
   logic hit_cnv;
   logic hit_st;
   logic [15:0] new_div;

   always_comb begin
      wr_acc = psel_i && penable_i && pwrite_i && !st_r.pready;
      rd_acc = psel_i && penable_i && !pwrite_i && !st_r.pready;
      hit_div = paddr_i == `CRC_ADDR_DIVCTL;
      hit_tim = paddr_i == `CRC_ADDR_TIMCTL;
      hit_cnv = paddr_i == `CRC_ADDR_CNVCTL;
      hit_st = paddr_i == `CRC_ADDR_STATUS;
      new_div = pwdata_i[15:0];
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.reinit = 1'b0;
      if (st_r.guard_cnt != 4'h0) begin
         st_nxt.guard_cnt = st_r.guard_cnt - 4'h1;
      end
      if (wr_acc) begin
         st_nxt.pready = 1'b1;
         if (hit_div) begin
            // only full halfword lane writes take effect
            if (pstrb_i[1:0] == 2'h3) begin
               st_nxt.divctl = new_div;
               if (new_div != st_r.divctl) begin
                  st_nxt.reinit = 1'b1;
                  st_nxt.reinit_seen = 1'b1;
               end
               if (field3(new_div, `CRC_DIV_BUS_LSB) != field3(st_r.divctl, `CRC_DIV_BUS_LSB)) begin
                  st_nxt.guard_cnt = `CRC_GUARD_CYCLES;
               end
            end
         end else if (hit_tim) begin
            if (pstrb_i[0]) begin
               st_nxt.timsel = pwdata_i[1:0];
            end
         end else if (hit_cnv) begin
            if (pstrb_i[0]) begin
               st_nxt.cnvsel = pwdata_i[1:0];
            end
         end else if (hit_st) begin
            // write one clears the sticky reinit flag; a new event wins
            if (pwdata_i[`CRC_ST_REINIT_BIT] && !st_nxt.reinit) begin
               st_nxt.reinit_seen = 1'b0;
            end
         end else begin
            st_nxt.pslverr = 1'b1;
         end
      end
      if (rd_acc) begin
         st_nxt.pready = 1'b1;
         st_nxt.prdata = 32'h0000_0000;
         if (hit_div) begin
            st_nxt.prdata[15:0] = st_r.divctl;
         end else if (hit_tim) begin
            st_nxt.prdata[7:0] = aux_image(st_r.timsel);
         end else if (hit_cnv) begin
            st_nxt.prdata[7:0] = aux_image(st_r.cnvsel);
         end else if (hit_st) begin
            st_nxt.prdata[`CRC_ST_GUARD_BIT] = st_r.guard_cnt != 4'h0;
            st_nxt.prdata[`CRC_ST_REINIT_BIT] = st_r.reinit_seen;
            st_nxt.prdata[`CRC_ST_OSCSTOP_BIT] = osc_stop_i;
         end else begin
            st_nxt.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         st_r.divctl <= `CRC_DIVCTL_RESET;
         st_r.timsel <= 2'(`CRC_AUXCTL_RESET & 8'h03);
         st_r.cnvsel <= 2'(`CRC_AUXCTL_RESET & 8'h03);
         st_r.guard_cnt <= 4'h0;
         st_r.reinit <= 1'b0;
         st_r.reinit_seen <= 1'b0;
         st_r.prdata <= 32'h0000_0000;
         st_r.pready <= 1'b0;
         st_r.pslverr <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // pin stage and ratio outputs, registered
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         clk_pin_r <= 1'b0;
         clk_pin_oe_r <= 1'b1;
         hiz_r <= 1'b0;
         tim_en_r <= 1'b1;
         cnv_en_r <= 1'b1;
         ratios_r <= '0;
      end else begin
         // forced low while the bus ratio switches
         clk_pin_r <= (st_nxt.guard_cnt == 4'h0) && ref_clk_level_i;
         clk_pin_oe_r <= !standby_i || st_nxt.divctl[`CRC_DIV_STBY_CKOE_BIT];
         hiz_r <= osc_stop_i;
         tim_en_r <= st_nxt.timsel != 2'h0;
         cnv_en_r <= st_nxt.cnvsel != 2'h0;
         ratios_r.int_div <= field3(st_nxt.divctl, `CRC_DIV_INT_LSB);
         ratios_r.bus_div <= field3(st_nxt.divctl, `CRC_DIV_BUS_LSB);
         ratios_r.per_div <= field3(st_nxt.divctl, `CRC_DIV_PER_LSB);
         ratios_r.tim_div <= st_nxt.timsel;
         ratios_r.cnv_div <= st_nxt.cnvsel;
      end
   end

   assign prdata_o = st_r.prdata;
   assign pready_o = st_r.pready;
   assign pslverr_o = st_r.pslverr;
   assign ratios_o = ratios_r;
   assign clk_pin_o = clk_pin_r;
   assign clk_pin_oe_o = clk_pin_oe_r;
   assign tim_clk_en_o = tim_en_r;
   assign cnv_clk_en_o = cnv_en_r;
   assign reinit_o = st_r.reinit;
   assign hc_pins_hiz_o = hiz_r;
endmodule : crc_clock_ratio_control

// [crc_clock_ratio_control_sva.sv]
`timescale 1ns/1ps
module crc_clock_ratio_control_sva import crc_pkg::*; (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic pready_o,
   input wire logic standby_i,
   input wire logic osc_stop_i,
   input wire logic ref_clk_level_i,
   input wire crc_ratios_t ratios_o,
   input wire logic clk_pin_o,
   input wire logic clk_pin_oe_o,
   input wire logic tim_clk_en_o,
   input wire logic cnv_clk_en_o,
   input wire logic reinit_o,
   input wire logic hc_pins_hiz_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   a_ready_next: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("access not answered");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready held");
   a_reset_ratio: assert property ($fell(reset_i) |=> ratios_o == 13'h0DBF)
      else $error("reset ratios wrong");
   a_guard_low: assert property (!$past(reset_i, 2) && $changed(ratios_o.bus_div)
      |-> !clk_pin_o ##1 clk_pin_o == $past(ref_clk_level_i)) else $error("clock pin guard wrong");
   a_reinit_cause: assert property (reinit_o |-> pready_o && $past(pwrite_i) && paddr_i == 12'h000)
      else $error("stray reinit");
   a_oe_run: assert property (!$past(standby_i) |-> clk_pin_oe_o)
      else $error("pin enable off");
   a_hiz_follow: assert property (!$past(reset_i) |-> hc_pins_hiz_o == $past(osc_stop_i))
      else $error("hiz wrong");
   a_clk_en: assert property (!$past(reset_i) |-> tim_clk_en_o == (ratios_o.tim_div != 2'h0)
      && cnv_clk_en_o == (ratios_o.cnv_div != 2'h0)) else $error("clock enable wrong");
endmodule : crc_clock_ratio_control_sva
bind crc_clock_ratio_control crc_clock_ratio_control_sva u_sva (.*);

// [crc_clock_ratio_control_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; $display("wrong value %s exp %h got %h", n, e, a); end end
module crc_clock_ratio_control_tb;
   import crc_pkg::*;
   logic clk_sys_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic [3:0] pstrb_i = 4'hF; // word lanes only
   logic standby_i = 0, osc_stop_i = 0, ref_clk_level_i = 0, pready_o, pslverr_o, er, pin, rn;
   logic clk_pin_o, clk_pin_oe_o, tim_clk_en_o, cnv_clk_en_o, reinit_o, hc_pins_hiz_o;
   crc_ratios_t ratios_o;
   int miscompares = 0, samples_checked = 0, cycles = 0;
   crc_clock_ratio_control DUT (.*);
   initial forever #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      ref_clk_level_i <= ~ref_clk_level_i;
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         test_done();
      end
   end
   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_sys_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      pin = clk_pin_o;
      rn = reinit_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : xfer
   task t_reset;
      xfer(1'b0, 12'h000, 32'h0);
      `CHK("divider", 32'h0333, rd)
      xfer(1'b0, 12'h004, 32'h0);
      `CHK("timer", 32'h43, rd)
      xfer(1'b0, 12'h008, 32'h0);
      `CHK("converter", 32'h43, rd)
      $display("reset test done");
   endtask : t_reset
   task t_div;
      xfer(1'b1, 12'h000, 32'h1555); // ratios kept in legal order
      `CHK("guard pin", 1'b0, pin)
      `CHK("reinit pulse", 1'b1, rn)
      xfer(1'b0, 12'h000, 32'h0);
      `CHK("divider", 32'h1555, rd)
      `CHK("ratios", 13'h16DF, ratios_o)
      xfer(1'b0, 12'h00C, 32'h0);
      `CHK("reinit flag", 1'b1, rd[1])
      xfer(1'b1, 12'h00C, 32'h2);
      xfer(1'b0, 12'h00C, 32'h0);
      `CHK("reinit cleared", 1'b0, rd[1])
      xfer(1'b1, 12'h000, 32'h1555);
      `CHK("no reinit", 1'b0, rn)
      repeat (32) @(posedge clk_sys_i); // settle idle
      standby_i <= 1'b1;
      xfer(1'b1, 12'h000, 32'h0555);
      `CHK("standby pin off", 1'b0, clk_pin_oe_o)
      xfer(1'b1, 12'h000, 32'h1555);
      `CHK("standby pin on", 1'b1, clk_pin_oe_o)
      standby_i <= 1'b0;
      $display("divider test done");
   endtask : t_div
   task t_aux;
      logic [11:0] a;
      for (int i = 0; i < 2; i++) begin
         a = 12'h004 + 12'(i * 4);
         xfer(1'b1, a, 32'hFF);
         xfer(1'b0, a, 32'h0);
         `CHK("aux fixed bits", 32'h43, rd)
         xfer(1'b1, a, 32'h0);
         xfer(1'b0, a, 32'h0);
         `CHK("aux ratio", 32'h40, rd)
      end
      `CHK("clock enables", 2'b00, {tim_clk_en_o, cnv_clk_en_o})
      $display("aux test done");
   endtask : t_aux
   task t_misc;
      xfer(1'b0, 12'h010, 32'h0);
      `CHK("unmapped error", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
      osc_stop_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      `CHK("pins hiz", 1'b1, hc_pins_hiz_o)
      osc_stop_i <= 1'b0;
      $display("misc test done");
   endtask : t_misc
   initial begin
      repeat (6) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      t_reset;
      t_div; // divider set before aux setup
      t_aux;
      t_misc;
      test_done;
   end
endmodule : crc_clock_ratio_control_tb

// [crc_params.svh]
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH

// register byte addresses on the apb slave
`define CRC_ADDR_DIVCTL 12'h000
`define CRC_ADDR_TIMCTL 12'h004
`define CRC_ADDR_CNVCTL 12'h008
`define CRC_ADDR_STATUS 12'h00C

// reset values
`define CRC_DIVCTL_RESET 16'h0333
`define CRC_AUXCTL_RESET 8'h43
// fixed upper bits of the 8-bit clock control registers
`define CRC_AUX_FIXED 6'h10

// divider control field positions
`define CRC_DIV_STBY_CKOE_BIT 12
`define CRC_DIV_INT_LSB 8
`define CRC_DIV_BUS_LSB 4
`define CRC_DIV_PER_LSB 0
`define CRC_DIV_FIELD_W 3

// status register field positions
`define CRC_ST_GUARD_BIT 0
`define CRC_ST_REINIT_BIT 1
`define CRC_ST_OSCSTOP_BIT 2

// ticks of the input clock the pin is held low on a bus ratio switch
`define CRC_GUARD_CYCLES 4'h1

`endif

// [crc_pkg.sv]
package crc_pkg;
   typedef struct packed {
      logic [15:0] divctl;
      logic [1:0] timsel;
      logic [1:0] cnvsel;
      logic [3:0] guard_cnt;
      logic reinit;
      logic reinit_seen;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } crc_state_t;

   typedef struct packed {
      logic [2:0] int_div;
      logic [2:0] bus_div;
      logic [2:0] per_div;
      logic [1:0] tim_div;
      logic [1:0] cnv_div;
   } crc_ratios_t;
endpackage : crc_pkg
